// *** hdl/link_supervisor_pkg.sv ***
// constants, register map and field layouts for the serial link supervisor
// assumes a 125 MHz converter-side clock and a 32-bit classic wishbone slave port
package link_supervisor_pkg;

    // bus geometry
    localparam int unsigned ADR_W = 12;
    localparam int unsigned DAT_W = 32;
    localparam int unsigned IDX_W = 10;
    localparam int unsigned IDX_LSB = 2;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_LINK_CTRL = 10'h100;
    localparam logic [IDX_W-1:0] IDX_LINK_STAT = 10'h101;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT  = 10'h102;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLR   = 10'h103;
    localparam logic [IDX_W-1:0] IDX_IRQ_EN    = 10'h104;
    localparam logic [IDX_W-1:0] IDX_WD_COUNT  = 10'h105;
    localparam logic [IDX_W-1:0] IDX_PRBS_TEST = 10'h121;
    localparam logic [IDX_W-1:0] IDX_WD_CFG    = 10'h124;
    localparam logic [IDX_W-1:0] IDX_ERROR_PULSE_WIDTH  = 10'h127;

    // reset values of the documented registers
    localparam logic [7:0] PRBS_TEST_RST = 8'h00;
    localparam logic [7:0] WD_CFG_RST    = 8'h00;
    localparam logic [7:0] ERROR_PULSE_WIDTH_RST  = 8'h00;

    // test pattern codes; 5 to 31 are reserved and behave as normal operation
    typedef enum logic [4:0] {
        PRBS_OFF = 5'h00,
        PRBS_7   = 5'h01,
        PRBS_9   = 5'h02,
        PRBS_15  = 5'h03,
        PRBS_31  = 5'h04
    } prbs_mode_t;

    // watchdog configuration layout, bit 7 down to bit 0
    typedef struct packed {
        logic       pll_reset_on_expiry;
        logic       rsvd6;
        logic [1:0] uptime_decrement_select;
        logic       rsvd3;
        logic [2:0] expiry_threshold_select;
    } wd_cfg_t;

    // error pulse width layout
    typedef struct packed {
        logic [4:0] rsvd;
        logic [2:0] error_pulse_width;
    } error_pulse_width_t;

    // reset requests toward the phy
    typedef struct packed {
        logic pll;
        logic rx;
    } phy_reset_t;

    // sticky event layout shared by status, clear and enable
    typedef struct packed {
        logic link_lost;
        logic err_report;
        logic expiry;
    } irq_vec_t;

    localparam int unsigned IRQ_W = $bits(irq_vec_t);

    // decrement steps per select code
    localparam logic [4:0] DEC_STEP_0 = 5'h01;
    localparam logic [4:0] DEC_STEP_1 = 5'h02;
    localparam logic [4:0] DEC_STEP_2 = 5'h08;
    localparam logic [4:0] DEC_STEP_3 = 5'h10;

    // timing
    localparam int unsigned CLK_PERIOD_NS    = 8;
    localparam int unsigned PHY_RST_NS       = 64;
    localparam int unsigned PHY_RST_CYC      = (PHY_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned UPTIME_MIN_CYC   = 1024;
    localparam int unsigned CHARS_PER_LINK_CK = 4;

endpackage : link_supervisor_pkg

// *** hdl/link_supervisor.sv ***
// supervision and test control for a multi-lane serial receive link:
// prbs pattern select, link watchdog with phy/pll reset, sync error pulses
// assumes status inputs synchronous to clk_i and a classic wishbone master
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module link_supervisor
    import link_supervisor_pkg::*;
#(
    parameter int unsigned CNT_W      = 24,
    parameter int unsigned THRESH_1   = 32'h0002_0000,
    parameter int unsigned THRESH_2   = 32'h0008_0000,
    parameter int unsigned THRESH_3   = 32'h0020_0000,
    parameter int unsigned THRESH_4   = 32'h0080_0000,
    parameter int unsigned UPTIME_MIN = link_supervisor_pkg::UPTIME_MIN_CYC,
    parameter int unsigned LINK_DIV   = 4
) (
    // clock and reset
    input  wire  logic                                  clk_i,
    input  wire  logic                                  rst_i,
    // wishbone slave
    input  wire  logic                                  cyc_i,
    input  wire  logic                                  stb_i,
    input  wire  logic                                  we_i,
    input  wire  logic [link_supervisor_pkg::ADR_W-1:0] adr_i,
    input  wire  logic [3:0]                            sel_i,
    input  wire  logic [link_supervisor_pkg::DAT_W-1:0] dat_i,
    output logic       [link_supervisor_pkg::DAT_W-1:0] dat_o,
    output logic                                        ack_o,
    // link status from the receiver
    input  wire  logic                                  link_up_i,
    input  wire  logic                                  crc_fault_i,
    input  wire  logic                                  soft_error_i,
    input  wire  logic                                  resync_req_i,
    // controls toward the receiver and phy
    output link_supervisor_pkg::prbs_mode_t             prbs_mode_o,
    output logic                                        link_enable_o,
    output link_supervisor_pkg::phy_reset_t             phy_reset_o,
    output logic                                        sync_n_o,
    output logic                                        irq_o
);
    import link_supervisor_pkg::*;

    // counter widths sized from the parameters so short sim values stay legal
    localparam int unsigned UP_W  = $clog2(UPTIME_MIN + 1);
    localparam int unsigned DIV_W = $clog2(LINK_DIV + 1);
    localparam int unsigned RST_W = $clog2(PHY_RST_CYC + 1);

    // register state
    logic [4:0]           prbs_sel_q;
    wd_cfg_t              wd_cfg_q;
    error_pulse_width_t            error_pulse_width_q;
    logic                 link_en_q;
    irq_vec_t             irq_stat_q;
    irq_vec_t             irq_en_q;
    logic                 ack_q;
    logic [DAT_W-1:0]     dat_q;
    logic [DAT_W-1:0]     rdata_d;

    // watchdog state
    logic [CNT_W-1:0]     wd_cnt_q;
    logic [CNT_W-1:0]     wd_cnt_d;
    logic [CNT_W-1:0]     thresh;
    logic [4:0]           dec_step;
    logic                 wd_armed;
    logic                 expiry;
    logic [UP_W-1:0]      uptime_q;
    logic                 healthy;
    logic                 credited;
    logic [RST_W-1:0]     rst_cnt_q;
    logic                 rst_pll_q;

    // sync error pulse state
    logic [DIV_W-1:0]     div_q;
    logic                 link_tick;
    logic [2:0]           pulse_left_q;
    logic                 pulse_start;
    logic                 link_up_q;
    logic                 irq_q;

    // bus decode
    logic                 req;
    logic                 wr;
    logic [IDX_W-1:0]     idx;
    irq_vec_t             irq_event;
    irq_vec_t             irq_clr;

    // a request is fresh only while no ack stands, so one cycle is one access
    assign req = cyc_i & stb_i & ~ack_q;
    assign wr  = req & we_i & sel_i[0];
    assign idx = adr_i[IDX_LSB +: IDX_W];

    // one wait state per access; ack drops in the cycle after it was given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // read data is latched with the request so it stands with ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= '0;
        end else if (req && !we_i) begin
            dat_q <= rdata_d;
        end
    end

    // read mux; unmapped and write-only locations read as zero
    always_comb begin
        rdata_d = '0;
        unique case (idx)
            IDX_LINK_CTRL: rdata_d[0]          = link_en_q;
            IDX_LINK_STAT: rdata_d[3:0]        = {sync_n_o, |rst_cnt_q, wd_armed, link_up_i};
            IDX_IRQ_STAT:  rdata_d[IRQ_W-1:0]  = irq_stat_q;
            IDX_IRQ_EN:    rdata_d[IRQ_W-1:0]  = irq_en_q;
            IDX_WD_COUNT:  rdata_d[CNT_W-1:0]  = wd_cnt_q;
            IDX_PRBS_TEST: rdata_d[4:0]        = prbs_sel_q;
            IDX_WD_CFG:    rdata_d[7:0]        = wd_cfg_q;
            IDX_ERROR_PULSE_WIDTH:  rdata_d[7:0]        = error_pulse_width_q;
            default:       rdata_d             = '0;
        endcase
    end

    // configuration writes; settings are not locked while enabled, the
    // hardware simply follows them, so rewriting a live link is undefined
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prbs_sel_q <= PRBS_TEST_RST[4:0];
            wd_cfg_q   <= wd_cfg_t'(WD_CFG_RST);
            error_pulse_width_q <= error_pulse_width_t'(ERROR_PULSE_WIDTH_RST);
            link_en_q  <= 1'b0;
            irq_en_q   <= '0;
        end else if (wr) begin
            unique case (idx)
                IDX_LINK_CTRL: link_en_q  <= dat_i[0];
                IDX_PRBS_TEST: prbs_sel_q <= dat_i[4:0];
                IDX_WD_CFG:    wd_cfg_q   <= wd_cfg_t'(dat_i[7:0]);
                IDX_ERROR_PULSE_WIDTH:  error_pulse_width_q <= error_pulse_width_t'(dat_i[7:0]);
                IDX_IRQ_EN:    irq_en_q   <= irq_vec_t'(dat_i[IRQ_W-1:0]);
                default:       ;
            endcase
        end
    end

    // pattern decode; reserved codes fall back to normal operation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prbs_mode_o <= PRBS_OFF;
        end else begin
            unique case (prbs_sel_q)
                PRBS_7:  prbs_mode_o <= PRBS_7;
                PRBS_9:  prbs_mode_o <= PRBS_9;
                PRBS_15: prbs_mode_o <= PRBS_15;
                PRBS_31: prbs_mode_o <= PRBS_31;
                default: prbs_mode_o <= PRBS_OFF;
            endcase
        end
    end

    // link enable goes straight out of its flip-flop
    assign link_enable_o = link_en_q;

    // threshold and step selection
    always_comb begin
        thresh   = '0;
        wd_armed = 1'b0;
        dec_step = DEC_STEP_0;
        unique case (wd_cfg_q.expiry_threshold_select)
            3'd1: begin
                thresh   = CNT_W'(THRESH_1);
                wd_armed = link_en_q;
            end
            3'd2: begin
                thresh   = CNT_W'(THRESH_2);
                wd_armed = link_en_q;
            end
            3'd3: begin
                thresh   = CNT_W'(THRESH_3);
                wd_armed = link_en_q;
            end
            3'd4: begin
                thresh   = CNT_W'(THRESH_4);
                wd_armed = link_en_q;
            end
            default: begin
                thresh   = '0;
                wd_armed = 1'b0;
            end
        endcase
        unique case (wd_cfg_q.uptime_decrement_select)
            2'd0: dec_step = DEC_STEP_0;
            2'd1: dec_step = DEC_STEP_1;
            2'd2: dec_step = DEC_STEP_2;
            2'd3: dec_step = DEC_STEP_3;
        endcase
    end

    // a crc alarm counts as down, an up link with bad data is no credit
    assign healthy  = link_up_i & ~crc_fault_i;
    assign credited = healthy & (uptime_q == UP_W'(UPTIME_MIN));

    // uptime qualifier: short bursts of link-up are not credited, which keeps
    // a flapping link from holding the counter down
    always_ff @(posedge clk_i) begin
        if (rst_i || !healthy) begin
            uptime_q <= '0;
        end else if (uptime_q != UP_W'(UPTIME_MIN)) begin
            uptime_q <= uptime_q + 1'b1;
        end
    end

    // next count: climb while down, fall by the step while credited
    always_comb begin
        wd_cnt_d = wd_cnt_q;
        if (!healthy) begin
            wd_cnt_d = wd_cnt_q + 1'b1;
        end else if (credited) begin
            if (wd_cnt_q > CNT_W'(dec_step)) begin
                wd_cnt_d = wd_cnt_q - CNT_W'(dec_step);
            end else begin
                wd_cnt_d = '0;
            end
        end
    end

    // no second expiry while the phy is still held, the pulse stays whole
    assign expiry = wd_armed && (wd_cnt_q >= thresh) && (rst_cnt_q == '0);

    // watchdog counter; cleared while disarmed or at expiry, frozen while the phy is held in reset
    always_ff @(posedge clk_i) begin
        if (rst_i || !wd_armed || expiry) begin
            wd_cnt_q <= '0;
        end else if (rst_cnt_q == '0) begin
            wd_cnt_q <= wd_cnt_d;
        end
    end

    // phy reset stretcher; pll choice is latched at expiry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_cnt_q <= '0;
            rst_pll_q <= 1'b0;
        end else if (expiry) begin
            rst_cnt_q <= RST_W'(PHY_RST_CYC);
            rst_pll_q <= wd_cfg_q.pll_reset_on_expiry;
        end else if (rst_cnt_q != '0) begin
            rst_cnt_q <= rst_cnt_q - 1'b1;
        end
    end

    // reset outputs decoded from the stretcher count
    assign phy_reset_o.rx  = (rst_cnt_q != '0);
    assign phy_reset_o.pll = (rst_cnt_q != '0) & rst_pll_q;

    // link clock enable; restarted at each pulse so a pulse is whole periods
    assign pulse_start = link_en_q && soft_error_i && (error_pulse_width_q.error_pulse_width != '0)
                         && (pulse_left_q == '0);
    assign link_tick   = (div_q == DIV_W'(LINK_DIV - 1));

    // divider for the link clock enable; free running between pulses
    always_ff @(posedge clk_i) begin
        if (rst_i || pulse_start || link_tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // error pulse length in link clocks; errors during a pulse are merged
    always_ff @(posedge clk_i) begin
        if (rst_i || !link_en_q) begin
            pulse_left_q <= '0;
        end else if (pulse_start) begin
            pulse_left_q <= error_pulse_width_q.error_pulse_width;
        end else if (link_tick && pulse_left_q != '0) begin
            pulse_left_q <= pulse_left_q - 1'b1;
        end
    end

    // sync line: low requests resync or reports an error, high when idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_n_o <= 1'b1;
        end else begin
            sync_n_o <= ~((link_en_q & resync_req_i) | pulse_start | (pulse_left_q > 3'd1)
                          | (pulse_left_q == 3'd1 && !link_tick));
        end
    end

    // event sources for the interrupt status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_up_q <= 1'b0;
        end else begin
            link_up_q <= link_up_i;
        end
    end

    assign irq_event.expiry     = expiry;
    assign irq_event.err_report = pulse_start;
    assign irq_event.link_lost  = link_up_q & ~link_up_i & link_en_q;
    assign irq_clr              = (wr && idx == IDX_IRQ_CLR) ? irq_vec_t'(dat_i[IRQ_W-1:0]) : '0;

    // sticky status; an event in the clearing cycle survives the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_event;
        end
    end

    // level interrupt, one cycle behind the status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_en_q);
        end
    end

    // all outputs below come from flip-flops
    assign irq_o = irq_q;
    assign ack_o = ack_q;
    assign dat_o = dat_q;

endmodule // link_supervisor

`default_nettype wire

// *** tb/sup_chk.sv ***
// checker: bus, sync pulse, phy reset and prbs relations at the supervisor ports
// assumes one clock domain and a bind onto link_supervisor
`timescale 1ns/100ps
`default_nettype none
module sup_chk
    import link_supervisor_pkg::*;
(
    // clock, reset and bus
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       ack_o,
    // link side
    input wire logic       soft_error_i,
    input wire logic       resync_req_i,
    input wire prbs_mode_t prbs_mode_o,
    input wire phy_reset_t phy_reset_o,
    input wire logic       sync_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // bus answers exactly one cycle after a fresh request, for one cycle
    property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    // reset leaves the sync line released and the phy out of reset
    property p_rst;
        disable iff (1'b0) rst_i |=> sync_n_o && prbs_mode_o == PRBS_OFF && phy_reset_o == 2'b00;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_prbs; prbs_mode_o <= PRBS_31; endproperty
    a_prbs: assert property (p_prbs) else $error("pattern code illegal");
    // a sync pulse needs a cause; one not caused by a resync request spans at least one link clock
    property p_sync_src; $fell(sync_n_o) |-> $past(soft_error_i) || $past(resync_req_i); endproperty
    a_sync_src: assert property (p_sync_src) else $error("sync without cause");
    property p_sync_min; $fell(sync_n_o) && !$past(resync_req_i) |-> !sync_n_o [*4]; endproperty
    a_sync_min: assert property (p_sync_min) else $error("sync pulse short");
    // phy reset lasts eight cycles; pll only ever together with rx
    property p_phy_len; $rose(phy_reset_o.rx) |-> phy_reset_o.rx [*8] ##1 !phy_reset_o.rx; endproperty
    a_phy_len: assert property (p_phy_len) else $error("phy reset length");
    property p_pll; phy_reset_o.pll |-> phy_reset_o.rx; endproperty
    a_pll: assert property (p_pll) else $error("pll reset alone");
    c_pll: cover property ($rose(phy_reset_o.pll));
    c_rx: cover property ($rose(phy_reset_o.rx) && !phy_reset_o.pll);
    c_sync: cover property ($fell(sync_n_o));
endmodule // sup_chk
bind link_supervisor sup_chk i_sup_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .soft_error_i(soft_error_i), .resync_req_i(resync_req_i), .prbs_mode_o(prbs_mode_o),
    .phy_reset_o(phy_reset_o), .sync_n_o(sync_n_o));
`default_nettype wire

// *** tb/link_model.sv ***
// far-side link model: receiver status toward the supervisor, sync line watcher
// assumes bench commands change right after rising clock edges
`timescale 1ns/100ps
`default_nettype none
module link_model
    import link_supervisor_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // commands from the bench
    input  wire logic       up_i,
    input  wire logic       crc_i,
    input  wire logic       err_i,
    input  wire logic       clr_i,
    input  wire logic       rsy_i,
    // from and toward the supervisor
    input  wire phy_reset_t phy_reset_i,
    input  wire logic       sync_n_i,
    output logic            link_up_o,
    output logic            crc_fault_o,
    output logic            soft_error_o,
    output logic            resync_req_o,
    output logic [7:0]      low_cnt_o
);
    // lanes drop while the phy is held in reset, a real receiver cannot stay up
    always_ff @(posedge clk_i) begin
        link_up_o    <= !rst_i && up_i && !phy_reset_i.rx;
        crc_fault_o  <= !rst_i && crc_i;
        soft_error_o <= !rst_i && err_i;
        resync_req_o <= !rst_i && rsy_i; // link layer asking for a full resync
    end
    // low-active request line measured in clock cycles
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) low_cnt_o <= 8'h00;
        else if (!sync_n_i) low_cnt_o <= low_cnt_o + 8'h01;
    end
endmodule // link_model
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the link supervisor
// assumes the checker bind is compiled alongside and short sim thresholds
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import link_supervisor_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [11:0] adr_i = 12'h000;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, rd, c1;
    logic        ack_o, link_up, crc_fault, soft_error, resync_req, link_enable_o, sync_n_o, irq_o;
    logic        up = 1'b0, crc = 1'b0, err = 1'b0, clr = 1'b0, rsy = 1'b0;
    logic [3:0]  sel_i = 4'hF, wsel = 4'hF;
    logic [7:0]  low_cnt;
    prbs_mode_t  prbs_mode_o;
    phy_reset_t  phy_reset_o;
    int          mismatches = 0, checks_done = 0, n;
    int          steps [4] = '{1, 2, 8, 16};
    logic [9:0]  ix [3];
    logic [31:0] msk [3];
    always #4 clk_i = ~clk_i;
    // short thresholds keep the watchdog runs brief
    link_supervisor #(.THRESH_1(64), .THRESH_2(128), .THRESH_3(256), .THRESH_4(512), .UPTIME_MIN(8))
    i_link_supervisor (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .link_up_i(link_up),
        .crc_fault_i(crc_fault), .soft_error_i(soft_error), .resync_req_i(resync_req),
        .prbs_mode_o(prbs_mode_o), .link_enable_o(link_enable_o), .phy_reset_o(phy_reset_o),
        .sync_n_o(sync_n_o), .irq_o(irq_o));
    link_model i_link_model (.clk_i(clk_i), .rst_i(rst_i), .up_i(up), .crc_i(crc), .err_i(err),
        .clr_i(clr), .rsy_i(rsy), .phy_reset_i(phy_reset_o), .sync_n_i(sync_n_o), .link_up_o(link_up),
        .crc_fault_o(crc_fault), .soft_error_o(soft_error), .resync_req_o(resync_req), .low_cnt_o(low_cnt));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one classic wishbone cycle; read data taken at the ack edge
    task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= {a, 2'b00}; dat_i <= d;
        sel_i <= wsel;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0;
    endtask
    task automatic t_regs;
        ix = '{IDX_PRBS_TEST, IDX_WD_CFG, IDX_ERROR_PULSE_WIDTH};
        msk = '{32'h0000_001F, 32'h0000_00FF, 32'h0000_00FF};
        for (int i = 0; i < 3; i++) begin
            wb(0, ix[i], 0); chk(rd, 32'h0000_0000);
            wb(1, ix[i], 32'hFFFF_FFFF); wb(0, ix[i], 0); chk(rd & msk[i], msk[i]);
            wb(1, ix[i], 0);
        end
        wsel = 4'hE;
        wb(1, IDX_PRBS_TEST, 32'h0000_0003);
        wsel = 4'hF;
        wb(0, IDX_PRBS_TEST, 0); chk(rd, 32'h0000_0000);
        wb(1, 10'h3FF, 32'h0000_00FF); wb(0, 10'h3FF, 0); chk(rd, 32'h0000_0000);
    endtask
    task automatic t_prbs;
        for (int c = 0; c < 8; c++) begin
            wb(1, IDX_PRBS_TEST, c);
            repeat (2) @(posedge clk_i);
            chk(prbs_mode_o, (c < 5) ? c : 0);
        end
    endtask
    // error burst of three cycles must merge into one pulse of 4*w cycles
    task automatic t_sync(input int w, input logic [31:0] en);
        wb(1, IDX_LINK_CTRL, 0); wb(1, IDX_ERROR_PULSE_WIDTH, w); wb(1, IDX_IRQ_EN, en);
        chk(link_enable_o, 1'b0);
        wb(1, IDX_LINK_CTRL, 1);
        chk(link_enable_o, 1'b1);
        clr <= 1'b1; @(posedge clk_i); clr <= 1'b0; err <= 1'b1;
        repeat (3) @(posedge clk_i);
        err <= 1'b0;
        repeat (40) @(posedge clk_i);
        chk(low_cnt, 4 * w);
        chk(sync_n_o, 1'b1);
        chk(irq_o, (w != 0) && en[1]);
        wb(0, IDX_IRQ_STAT, 0); chk(rd[1], w != 0);
        wb(1, IDX_IRQ_CLR, 32'h0000_0002); repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b0); wb(0, IDX_IRQ_STAT, 0); chk(rd[1], 1'b0);
    endtask
    // resync request of two cycles pulls sync low for two cycles
    task automatic t_resync;
        wb(1, IDX_LINK_CTRL, 1);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        rsy <= 1'b1;
        repeat (2) @(posedge clk_i);
        rsy <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk(low_cnt, 32'h0000_0002);
        chk(sync_n_o, 1'b1);
    endtask
    // link held down: count climbs to the threshold, then phy reset
    // f holds the link up with a crc alarm, which must count as down
    task automatic t_wd(input logic [31:0] cfg, input int t, input logic pll, input logic f);
        up <= f;
        crc <= f;
        wb(1, IDX_LINK_CTRL, 0); wb(1, IDX_WD_CFG, cfg); wb(1, IDX_LINK_CTRL, 1);
        n = 0;
        while (phy_reset_o.rx !== 1'b1 && n < 1000) begin
            @(posedge clk_i); n++;
        end
        if (t == 0) chk(n, 1000);
        else chk(n >= t - 2 && n <= t + 6, 1'b1);
        chk(phy_reset_o.pll, pll);
        wb(0, IDX_WD_COUNT, 0); chk(rd, 32'h0000_0000);
        wb(0, IDX_IRQ_STAT, 0); chk(rd[0], t != 0);
        wb(1, IDX_IRQ_CLR, 32'h0000_0001);
        up <= 1'b0;
        crc <= 1'b0;
    endtask
    // healthy link after a long outage: count falls in whole steps
    task automatic t_dec(input int s);
        wb(1, IDX_LINK_CTRL, 0); wb(1, IDX_WD_CFG, 32'h0000_0004 | (s << 4)); wb(1, IDX_LINK_CTRL, 1);
        repeat (400) @(posedge clk_i);
        up <= 1'b1;
        repeat (12) @(posedge clk_i);
        wb(0, IDX_WD_COUNT, 0); c1 = rd; wb(0, IDX_WD_COUNT, 0);
        chk(c1 - rd, 3 * steps[s]);
        up <= 1'b0;
    endtask
    task automatic give_verdict;
        if (mismatches == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #(8 * 40000);
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_prbs();
        t_sync(1, 2); t_sync(7, 2); t_sync(0, 2); t_sync(3, 0);
        t_resync();
        t_wd(32'h0000_0081, 64, 1'b1, 1'b0); t_wd(32'h0000_0002, 128, 1'b0, 1'b1);
        t_wd(32'h0000_0000, 0, 1'b0, 1'b0); t_wd(32'h0000_0005, 0, 1'b0, 1'b0);
        for (int s = 0; s < 4; s++) t_dec(s);
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
